// >>> bias_level_decode.v
/*
 * decodes the three-bit regulator level field into peak and offset.
 * assumes the field is a stable register output; purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

module bias_level_decode (
  input  wire [2:0] level_i,      // regulator level field
  output wire [8:0] peak_cv_o,    // peak output, 0.01 V units
  output wire [6:0] offset_cv_o   // lowest bias node offset, 0.01 V
);
`include "lcd_regs_defs.vh"

  // ========================================================
  // linear decode
  // each code step adds 0.13 V peak and removes 0.13 V offset
  wire [8:0] step_x_peak;         // code times step, wide
  wire [6:0] step_x_off;          // code times step, narrow

  assign step_x_peak = {6'h00, level_i} * {2'h0, `LEVEL_STEP_CV};
  assign step_x_off  = step_x_peak[6:0];
  assign peak_cv_o   = `PEAK_BASE_CV + step_x_peak;
  assign offset_cv_o = `OFFS_BASE_CV - step_x_off;

endmodule

`default_nettype wire

// >>> lcd_driver_config_and_pixel_map.v
/*
 * segment lcd register bank: charge pump and phase registers, segment
 * pin enables, 64-byte pixel map, write-allow guard and interrupts.
 * assumes an apb master on clk_i; lcd_tick_i is the selected lcd
 * clock as a synchronous pulse; waveform logic sits outside.
 */
// Added by the designer: the register offsets and the APB register port.
// How it works
// - level code 101 gives 3.34V peak, 0.26V offset
// - active flag reads 1 while driver runs
// - enable bit set makes pin an lcd segment
// - eight enable registers, eight segments each
// - pixel bit 1 dark, 0 clear
// - one bit per segment and common pair
// - byte index is common*8 plus segment/8
// - number of implemented segment groups is parameter
// - pixel write without allow sets sticky fail
// - frame divide ratio is field plus one
`timescale 1ns/100ps
`default_nettype none

module lcd_driver_config_and_pixel_map #(
  parameter SEG_REGS   = 8,       // implemented segment groups, 1..8
  parameter UPD_CYCLES = 2        // write-blocked cycles per frame
) (
  input  wire         clk_i,         // system clock, 100 MHz
  input  wire         arst_n_i,      // async reset, active low
  input  wire         ce_i,          // clock enable, freezes state
  input  wire         psel_i,        // apb select
  input  wire         penable_i,     // apb enable
  input  wire         pwrite_i,      // apb write
  input  wire [9:0]   paddr_i,       // apb byte address
  input  wire [31:0]  pwdata_i,      // apb write data
  output reg  [31:0]  prdata_o,      // apb read data
  output reg          pready_o,      // apb ready
  output reg          pslverr_o,     // apb error, unmapped address
  input  wire         lcd_tick_i,    // selected lcd clock pulse
  output wire         irq_o,         // level interrupt
  output reg  [63:0]  seg_lcd_en_o,  // 1 = pin drives lcd segment
  output reg  [511:0] pixel_o,       // frame-latched pixel map
  output wire         frame_o,       // frame boundary pulse
  output wire         active_o,      // driver running
  output wire [7:0]   pump_ctrl_o,   // charge pump settings
  output wire [1:0]   phase_mode_o,  // waveform type, bias scheme
  output wire [2:0]   com_sel_o,     // common count select
  output wire [8:0]   bias_peak_o,   // regulator peak, 0.01 V
  output wire [6:0]   bias_offset_o  // lowest bias offset, 0.01 V
);
`include "lcd_regs_defs.vh"

  // ========================================================
  // storage
  reg [7:0]         pump;            // charge_pump_control
  reg [1:0]         phase_mode;      // waveform type, bias scheme
  reg [3:0]         ratio;           // prescale_ratio
  reg               drv_on;          // software enable
  reg [2:0]         com_sel;         // common_count_select
  reg               driver_active;   // driver_active_flag
  reg [3:0]         upd_cnt;         // frame update blocking count
  reg [`IRQ_W-1:0]  irq_stat;        // sticky events
  reg [`IRQ_W-1:0]  irq_en;          // event enables
  reg [7:0]         seg_en [0:7];    // segment_pin_enable
  reg [7:0]         pix [0:63];      // pixel_data_byte

  // ========================================================
  // bus decode
  wire        access;                // access phase of a transfer
  wire        wr_fire;               // write takes effect now
  wire        hit_seg;               // segment enable window
  wire        hit_pix;               // pixel window
  wire [2:0]  seg_idx;               // segment register index
  wire [5:0]  pix_idx;               // pixel byte index
  wire        seg_impl;              // segment group present
  wire        pix_impl;              // pixel byte present
  wire        write_allow;           // write_allow_flag
  wire        wfail_ev;              // refused pixel write
  wire        frame_tick;            // divided lcd clock
  reg         mapped;                // address decodes
  reg  [31:0] next_rdata;            // read mux

  assign access   = psel_i & penable_i;
  assign wr_fire  = access & pready_o & pwrite_i & ce_i;
  assign hit_seg  = (paddr_i & `SEG_MASK) == `SEG_BASE;
  assign hit_pix  = (paddr_i & `PIX_MASK) == `PIX_BASE;
  assign seg_idx  = paddr_i[4:2];
  assign pix_idx  = paddr_i[7:2];
  // smaller variants drop the high segment groups
  assign seg_impl = {29'h0, seg_idx} < SEG_REGS;
  assign pix_impl = {29'h0, pix_idx[2:0]} < SEG_REGS;

  // no pixel writes during the frame latch window
  assign write_allow = ~driver_active | (upd_cnt == 4'h0);
  assign wfail_ev    = wr_fire & hit_pix & ~write_allow;

  // ========================================================
  // read mux; unimplemented bits read as zero
  always @* begin
    next_rdata = 32'h0;
    mapped     = 1'b1;
    if (hit_seg) begin
      if (seg_impl)
        next_rdata[7:0] = seg_en[seg_idx];
    end else if (hit_pix) begin
      if (pix_impl)
        next_rdata[7:0] = pix[pix_idx];
    end else begin
      case (paddr_i)
        `OFS_PUMP: begin
          next_rdata[7:0] = pump;
        end
        `OFS_PHASE: begin
          next_rdata[`WFT_BIT]      = phase_mode[1];
          next_rdata[`BIASMODE_BIT] = phase_mode[0];
          next_rdata[`ACTIVE_BIT]   = driver_active;
          next_rdata[`WALLOW_BIT]   = write_allow;
          next_rdata[`RATIO_HI:`RATIO_LO] = ratio;
        end
        `OFS_CTRL: begin
          next_rdata[`DRV_ON_BIT]           = drv_on;
          next_rdata[`COMSEL_HI:`COMSEL_LO] = com_sel;
        end
        `OFS_IRQ_STAT: begin
          next_rdata[`IRQ_W-1:0] = irq_stat;
        end
        `OFS_IRQ_EN: begin
          next_rdata[`IRQ_W-1:0] = irq_en;
        end
        `OFS_IRQ_CLR: begin
          next_rdata = 32'h0;       // write-only
        end
        `OFS_BIAS_RD: begin
          next_rdata[8:0]   = bias_peak_o;
          next_rdata[22:16] = bias_offset_o;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // apb answer: one wait state so read data comes from flops
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0;
    end else if (ce_i) begin
      if (access & ~pready_o) begin
        pready_o  <= 1'b1;
        pslverr_o <= ~mapped;
        prdata_o  <= pwrite_i ? 32'h0 : next_rdata;
      end else begin
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // ========================================================
  // control registers
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pump       <= `PUMP_RESET;
      phase_mode <= 2'h0;
      ratio      <= 4'h0;
      drv_on     <= 1'b0;
      com_sel    <= 3'h0;
      irq_en     <= {`IRQ_W{1'b0}};
    end else if (ce_i & wr_fire & mapped) begin
      case (paddr_i)
        `OFS_PUMP: begin
          // bit 6 is unimplemented and stays zero
          pump <= pwdata_i[7:0] & `PUMP_WMASK;
        end
        `OFS_PHASE: begin
          phase_mode <= {pwdata_i[`WFT_BIT], pwdata_i[`BIASMODE_BIT]};
          ratio      <= pwdata_i[`RATIO_HI:`RATIO_LO];
        end
        `OFS_CTRL: begin
          drv_on  <= pwdata_i[`DRV_ON_BIT];
          com_sel <= pwdata_i[`COMSEL_HI:`COMSEL_LO];
        end
        `OFS_IRQ_EN: begin
          irq_en <= pwdata_i[`IRQ_W-1:0];
        end
        default: begin
          irq_en <= irq_en;         // others handled elsewhere
        end
      endcase
    end
  end

  // ========================================================
  // sticky events; a new event beats a clear in the same cycle
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat <= {`IRQ_W{1'b0}};
    end else if (ce_i) begin
      if (wr_fire & (paddr_i == `OFS_IRQ_CLR))
        irq_stat <= (irq_stat & ~pwdata_i[`IRQ_W-1:0])
                  | {frame_tick, wfail_ev};
      else
        irq_stat <= irq_stat | {frame_tick, wfail_ev};
    end
  end

  assign irq_o = |(irq_stat & irq_en);

  // ========================================================
  // segment enables and pixel bytes, flops indexed by address
  integer k;
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (k = 0; k < 8; k = k + 1)
        seg_en[k] <= 8'h00;
      for (k = 0; k < 64; k = k + 1)
        pix[k] <= 8'h00;
    end else if (ce_i & wr_fire) begin
      if (hit_seg & seg_impl)
        seg_en[seg_idx] <= pwdata_i[7:0];
      // a refused write leaves the byte untouched
      if (hit_pix & pix_impl & write_allow)
        pix[pix_idx] <= pwdata_i[7:0];
    end
  end

  // ========================================================
  // frame timing and driver activity
  prescale_divider #(
    .W (4)
  ) u_prescale (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .run_i      (drv_on | driver_active),
    .lcd_tick_i (lcd_tick_i),
    .ratio_i    (ratio),
    .frame_o    (frame_tick)
  );

  // the driver starts and stops only on a frame boundary, so the
  // panel never sees a truncated frame
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      driver_active <= 1'b0;
      upd_cnt       <= 4'h0;
    end else if (ce_i) begin
      if (frame_tick) begin
        driver_active <= drv_on;
        upd_cnt       <= drv_on ? UPD_CYCLES[3:0] : 4'h0;
      end else if (upd_cnt != 4'h0) begin
        upd_cnt <= upd_cnt - 4'h1;
      end
    end
  end

  // ========================================================
  // output maps: enables per pin, pixels latched per frame
  integer j;                         // pixel byte index
  integer n;                         // segment group index

  // byte j is common j/8 and segments (j%8)*8 upward, so each
  // segment and common pair owns exactly one bit of the map
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pixel_o <= 512'h0;
    end else if (ce_i & frame_tick) begin
      for (j = 0; j < 64; j = j + 1) begin
        // a stopped driver shows a blank panel
        pixel_o[j*8 +: 8] <= drv_on ? pix[j] : 8'h00;
      end
    end
  end

  // pin modes follow the enable registers one cycle later
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seg_lcd_en_o <= 64'h0;
    end else if (ce_i) begin
      for (n = 0; n < 8; n = n + 1) begin
        seg_lcd_en_o[n*8 +: 8] <= seg_en[n];
      end
    end
  end

  // ========================================================
  // plain views of the settings
  assign frame_o      = frame_tick;
  assign active_o     = driver_active;
  assign pump_ctrl_o  = pump;
  assign phase_mode_o = phase_mode;
  assign com_sel_o    = com_sel;

  bias_level_decode u_bias (
    .level_i     (pump[`LEVEL_HI:`LEVEL_LO]),
    .peak_cv_o   (bias_peak_o),
    .offset_cv_o (bias_offset_o)
  );

endmodule

`default_nettype wire

// >>> lcd_panel_model.sv
/*
 lcd clock source model on the panel side: a tick every period_i cycles.
 assumes the bench sets period_i after a clock edge; 0 stops the ticks.
*/
`timescale 1ns/100ps
`default_nettype none
// ==========
// tick source
module lcd_panel_model (
  input  wire logic       clk_i,      // system clock
  input  wire logic       arst_n_i,   // async reset, active low
  input  wire logic [4:0] period_i,   // cycles per tick, 0 = stopped
  output var  logic       lcd_tick_o  // one-cycle lcd clock pulse
);
  logic [4:0] cnt;  // cycles since last tick
  // stopped clock sends no ticks at all, not a stuck-high pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 5'h00;
      lcd_tick_o <= 1'b0;
    end else begin
      lcd_tick_o <= (period_i != 5'h00) && (cnt + 5'h01 >= period_i);
      cnt <= (cnt + 5'h01 >= period_i) ? 5'h00 : cnt + 5'h01;
    end
  end
endmodule
`default_nettype wire

// >>> lcd_regs_chk.sv
/*
 port assertions of the lcd register bank.
 assumes a bind to the bank top with ce_i held high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lcd_regs_defs.vh"
module lcd_regs_chk (
  input wire logic         clk_i,         // clock
  input wire logic         arst_n_i,      // reset, active low
  input wire logic         psel_i,        // select
  input wire logic         penable_i,     // enable
  input wire logic         pwrite_i,      // write
  input wire logic [9:0]   paddr_i,       // address
  input wire logic [31:0]  prdata_o,      // read data
  input wire logic         pready_o,      // ready
  input wire logic         pslverr_o,     // error
  input wire logic         lcd_tick_i,    // lcd tick
  input wire logic         frame_o,       // frame pulse
  input wire logic         active_o,      // running
  input wire logic [63:0]  seg_lcd_en_o,  // pin modes
  input wire logic [511:0] pixel_o,       // pixel map
  input wire logic [7:0]   pump_ctrl_o,   // pump settings
  input wire logic [8:0]   bias_peak_o,   // peak
  input wire logic [6:0]   bias_offset_o  // offset
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========
  // bus steps
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence access_s;
    psel_i && penable_i && !pready_o;
  endsequence
  ready_wait_a: assert property (setup_s ##1 access_s |=> pready_o)
    else $error("ready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  err_ready_a: assert property (pslverr_o |-> pready_o && penable_i)
    else $error("error without ready");
  upper_zero_a: assert property (pready_o && !pwrite_i &&
    paddr_i != `OFS_BIAS_RD |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  // ==========
  // outputs and causes
  bias_dec_a: assert property (bias_peak_o == 9'h10D +
    {6'h00, pump_ctrl_o[5:3]} * 9'h00D &&
    bias_offset_o == 7'h5B - {4'h0, pump_ctrl_o[5:3]} * 7'h0D)
    else $error("bias decode wrong");
  active_frame_a: assert property (!$stable(active_o) |->
    frame_o || $past(frame_o)) else $error("active moved off frame");
  frame_tick_a: assert property (frame_o |-> $past(lcd_tick_i))
    else $error("frame without tick");
  // the write lands at the ready edge, the pins follow one edge later
  seg_write_a: assert property (!$stable(seg_lcd_en_o) |->
    $past(pready_o && pwrite_i, 2)) else $error("pin mode moved alone");
  pixel_frame_a: assert property (!$stable(pixel_o) |->
    $past(frame_o)) else $error("pixels moved alone");
endmodule
bind lcd_driver_config_and_pixel_map lcd_regs_chk u_chk (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .lcd_tick_i(lcd_tick_i), .frame_o(frame_o), .active_o(active_o),
  .seg_lcd_en_o(seg_lcd_en_o), .pixel_o(pixel_o),
  .pump_ctrl_o(pump_ctrl_o), .bias_peak_o(bias_peak_o),
  .bias_offset_o(bias_offset_o));
`default_nettype wire

// >>> lcd_regs_defs.vh
/*
 * constants of the segment lcd register bank: offsets, fields, resets.
 * assumes apb byte addresses, 10-bit address, one 32-bit word each.
 */
`ifndef LCD_REGS_DEFS_VH
`define LCD_REGS_DEFS_VH

// ==========================================================
// register byte offsets
`define OFS_PUMP      10'h000
`define OFS_PHASE     10'h004
`define OFS_CTRL      10'h008
`define OFS_IRQ_STAT  10'h00C
`define OFS_IRQ_EN    10'h010
`define OFS_IRQ_CLR   10'h014
`define OFS_BIAS_RD   10'h018
`define SEG_BASE      10'h040
`define SEG_MASK      10'h3E0
`define PIX_BASE      10'h100
`define PIX_MASK      10'h300

// ==========================================================
// charge_pump_control fields
`define PUMP_ON_BIT   7
`define LEVEL_HI      5
`define LEVEL_LO      3
`define THIRD_BIT     2
`define RCLK_HI       1
`define RCLK_LO       0
`define PUMP_RESET    8'h3C
`define PUMP_WMASK    8'hBF

// ==========================================================
// phase_prescale_status fields
`define WFT_BIT       7
`define BIASMODE_BIT  6
`define ACTIVE_BIT    5
`define WALLOW_BIT    4
`define RATIO_HI      3
`define RATIO_LO      0

// ==========================================================
// own control register fields
`define DRV_ON_BIT    0
`define COMSEL_HI     3
`define COMSEL_LO     1

// ==========================================================
// interrupt bits
`define IRQ_WFAIL     0
`define IRQ_FRAME     1
`define IRQ_W         2

// ==========================================================
// regulator level decode, in hundredths of a volt
`define PEAK_BASE_CV  9'h10D
`define OFFS_BASE_CV  7'h5B
`define LEVEL_STEP_CV 7'h0D

`endif

// >>> prescale_divider.v
/*
 * frame prescaler: divides the selected lcd clock tick by ratio+1.
 * assumes lcd_tick_i is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none

module prescale_divider #(
  parameter W = 4                 // ratio field width
) (
  input  wire         clk_i,      // system clock
  input  wire         arst_n_i,   // async reset, active low
  input  wire         ce_i,       // clock enable
  input  wire         run_i,      // divider running
  input  wire         lcd_tick_i, // selected lcd clock pulse
  input  wire [W-1:0] ratio_i,    // prescale field
  output reg          frame_o     // one pulse per divided period
);

  reg [W-1:0] count;              // ticks seen in this period

  // ========================================================
  // counter; restarts when stopped so the first period is full
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count   <= {W{1'b0}};
      frame_o <= 1'b0;
    end else if (ce_i) begin
      frame_o <= 1'b0;
      if (!run_i) begin
        count <= {W{1'b0}};
      end else if (lcd_tick_i) begin
        if (count == ratio_i) begin
          count   <= {W{1'b0}};
          frame_o <= 1'b1;
        end else begin
          count <= count + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench.sv
/*
 self-checking bench of the lcd register bank with six segment groups.
 assumes the bank, its defs header and the tick source model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "lcd_regs_defs.vh"
module testbench;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, tick, irq;
  logic frm, act, e;
  logic [1:0] pm;
  logic [2:0] cs;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdv, v;
  logic [63:0] seg;
  logic [511:0] pix;
  logic [7:0] pump, pv [64];
  logic [8:0] pk;
  logic [6:0] of;
  logic [4:0] period;
  int mismatches, n_tests, c;
  lcd_driver_config_and_pixel_map #(.SEG_REGS(6)) u_lcd_driver_config_and_pixel_map (
    .clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .lcd_tick_i(tick), .irq_o(irq),
    .seg_lcd_en_o(seg), .pixel_o(pix), .frame_o(frm), .active_o(act),
    .pump_ctrl_o(pump), .phase_mode_o(pm), .com_sel_o(cs),
    .bias_peak_o(pk), .bias_offset_o(of));
  lcd_panel_model u_lcd_panel_model (.clk_i(clk), .arst_n_i(arst_n),
    .period_i(period), .lcd_tick_o(tick));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========
  // checks and bus tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // request held until ready is sampled, then one idle edge
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin mismatches++; report_and_stop; end
  endtask
  // cycles until the next frame pulse, bounded
  task wf;
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (frm !== 1'b1 && c < 300);
    if (c >= 300) begin mismatches++; report_and_stop; end
  endtask
  function automatic logic [31:0] gexp(int k, logic [31:0] x);
    return (k % 8 < 6) ? (x & 32'hFF) : 32'h0;  // absent groups read 0
  endfunction
  // ==========
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    period = 5'h00; arst_n = 1'b0; mismatches = 0; n_tests = 0;
    v = $urandom(71647);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(0, `OFS_PUMP, 0); chk("pump rst", rdv, 32'h3C);
    chk("peak rst", 32'(pk), 32'd360);
    for (int l = 0; l < 8; l++) begin
      v = $urandom & 32'hFF;
      v[5:3] = 3'(l);
      apb(1, `OFS_PUMP, v); apb(0, `OFS_BIAS_RD, 0);
      chk("pump pins", 32'(pump), v & 32'hBF);
      chk("bias rd", rdv, 32'((91 - 13 * l) << 16 | (269 + 13 * l)));
      chk("peak", 32'(pk), 32'(269 + 13 * l));
      chk("offset", 32'(of), 32'(91 - 13 * l));
    end
    for (int k = 0; k < 8; k++) begin
      v = $urandom;
      apb(1, `SEG_BASE + 10'(4 * k), v); apb(0, `SEG_BASE + 10'(4 * k), 0);
      chk("seg rd", rdv, gexp(k, v));
      chk("seg pins", 32'(seg[8 * k +: 8]), gexp(k, v));
    end
    apb(0, 10'h020, 0); chk("unmapped", 32'(e), 32'h1);
    for (int i = 0; i < 64; i++) begin
      pv[i] = 8'($urandom);
      apb(1, `PIX_BASE + 10'(4 * i), 32'(pv[i]));
    end
    period <= 5'h02;
    apb(1, `OFS_PHASE, 32'hC0); apb(1, `OFS_CTRL, 32'h0F);
    repeat (3) wf;
    repeat (2) @(posedge clk);
    chk("active", 32'(act), 32'h1);
    chk("mode pins", 32'(pm), 32'h3);
    chk("com pins", 32'(cs), 32'h7);
    apb(0, `OFS_CTRL, 0); chk("ctrl rd", rdv, 32'h0F);
    apb(0, `OFS_PHASE, 0); chk("active bit", rdv & 32'h20, 32'h20);
    chk("phase rd", rdv & 32'hCF, 32'hC0);
    for (int i = 0; i < 512; i++) begin
      c = i / 64 * 8 + i % 64 / 8;  // byte holding segment i%64, common i/64
      v = gexp(c, pv[c]) >> (i % 8) & 1;
      chk("pixel", 32'(pix[i]), v);
    end
    foreach (pv[r]) if (r < 4) begin
      v = (r == 0) ? 0 : (r == 1) ? 1 : (r == 2) ? 15 : $urandom % 16;
      apb(1, `OFS_PHASE, v);
      repeat (2) wf;
      wf; chk("frame gap", 32'(c), 2 * (v + 1));
    end
    period <= 5'h01;
    apb(1, `OFS_PHASE, 0); apb(1, `OFS_IRQ_EN, 1);
    // let the counter wrap to the new ratio so frames come every cycle
    repeat (2) wf;
    apb(1, `PIX_BASE, 32'(~pv[0])); apb(0, `PIX_BASE, 0);
    chk("blocked write", rdv, 32'(pv[0]));
    apb(0, `OFS_PHASE, 0); chk("allow busy", rdv & 32'h30, 32'h20);
    apb(0, `OFS_IRQ_STAT, 0); chk("fail flag", rdv & 1, 32'h1);
    chk("frame flag", rdv & 2, 32'h2);
    chk("irq on", 32'(irq), 32'h1);
    apb(1, `OFS_IRQ_EN, 0); apb(0, `OFS_IRQ_EN, 0);
    chk("irq en rd", rdv, 32'h0);
    chk("irq masked", 32'(irq), 32'h0);
    apb(1, `OFS_IRQ_EN, 1); apb(1, `OFS_IRQ_CLR, 1); apb(0, `OFS_IRQ_STAT, 0);
    chk("fail cleared", rdv & 1, 32'h0);
    chk("irq off", 32'(irq), 32'h0);
    apb(1, `OFS_CTRL, 0);
    wf;
    repeat (3) @(posedge clk);
    chk("inactive", 32'(act), 32'h0);
    chk("pixels off", 32'(pix != 512'h0), 32'h0);
    apb(0, `OFS_PHASE, 0); chk("allow idle", rdv & 32'h30, 32'h10);
    report_and_stop;
  end
endmodule
`default_nettype wire
